//--- rtl/osc_pkg.sv
// Purpose: Constants, types and register map for the axis oscillation sequencer.
// Assumes: 250 MHz core clock, Avalon-MM register slave, 32-bit words.
// Notes:   Positions are signed 32-bit, feedrate unsigned 32-bit.
// How it works
// - Axis oscillates between two reversal points
// - One independent sequencer per axis
// - All traverses are linear feed moves
// - Control update sets then clears masked bits
// - Stop target selects reversal point on off
// - Option 4 parks after residual strokes
// - Option 8 deletion runs strokes then parks
// - Option 16 deletion approaches stop target
// - Option 32 defers feedrate to reversal
// - Option 64 rotary takes shortest route
// - Reversal positions absolute or relative plus offset
// - Dwell minus one coarse, zero fine, positive timed
// - Residual strokes go other point and back
// - Park only when option 4 or 8
// - Writing park position sets option 4
// - Switch one starts, zero requests stop
// - Busy holds program end until motion ends
// - Working limit enforced except on park and residual stroke moves, protection zones ignored
// - New point or dwell applied at next approach
// - Parameter writes accepted without stopping motion
// - Live reversal points readable as status
// - Work done once per cycle, overrun aborts
package osc_pkg;
   localparam int          addr_w          = 4;
   localparam logic [3:0]  reg_ctrl_set    = 4'h0;
   localparam logic [3:0]  reg_ctrl_clr    = 4'h1;
   localparam logic [3:0]  reg_pos_one     = 4'h2;
   localparam logic [3:0]  reg_pos_two     = 4'h3;
   localparam logic [3:0]  reg_dwell_one   = 4'h4;
   localparam logic [3:0]  reg_dwell_two   = 4'h5;
   localparam logic [3:0]  reg_feed        = 4'h6;
   localparam logic [3:0]  reg_strokes     = 4'h7;
   localparam logic [3:0]  reg_park        = 4'h8;
   localparam logic [3:0]  reg_switch      = 4'h9;
   localparam logic [3:0]  reg_offset      = 4'ha;
   localparam logic [3:0]  reg_status      = 4'hb;
   localparam logic [3:0]  reg_live_one    = 4'hc;
   localparam logic [3:0]  reg_live_two    = 4'hd;
   localparam logic [3:0]  reg_limits      = 4'he;
   localparam logic [3:0]  reg_limit_hi    = 4'hf;
   // Control word options
   localparam logic [6:0]  opt_target_msk  = 7'h03;
   localparam logic [6:0]  opt_park        = 7'h04;
   localparam logic [6:0]  opt_del_strokes = 7'h08;
   localparam logic [6:0]  opt_del_target  = 7'h10;
   localparam logic [6:0]  opt_feed_defer  = 7'h20;
   localparam logic [6:0]  opt_shortest    = 7'h40;
   localparam logic [1:0]  tgt_next        = 2'h0;
   localparam logic [1:0]  tgt_one         = 2'h1;
   localparam logic [1:0]  tgt_two         = 2'h2;
   localparam logic [1:0]  tgt_none        = 2'h3;
   localparam logic [31:0] dwell_coarse    = 32'hffffffff;
   localparam logic [31:0] dwell_fine      = 32'h00000000;
   // Timing
   localparam int          clk_mhz         = 250;
   localparam int          dwell_unit_us   = 1000000;
   localparam int          dwell_unit_cyc  = dwell_unit_us * clk_mhz;
   localparam int          ipo_cycle_us    = 4000;
   localparam int          ipo_cycle_cyc   = ipo_cycle_us * clk_mhz;
   localparam int          work_budget_cyc = 8;
   // Bit positions
   localparam int          st_busy         = 0;
   localparam int          st_active       = 1;
   localparam int          st_abort        = 2;
   localparam int          st_at_one       = 3;
   localparam int          st_limit        = 4;
   localparam int          lim_rotary      = 0;
   localparam int          lim_enable      = 1;
   localparam int          sw_on           = 0;
   localparam int          val_rel         = 31;

   typedef enum logic [3:0] {
      s_idle     = 4'h0,
      s_to_one   = 4'h1,
      s_to_two   = 4'h2,
      s_dwell    = 4'h3,
      s_stop_pt  = 4'h4,
      s_strokes  = 4'h5,
      s_park     = 4'h6,
      s_done     = 4'h7
   } seq_state_t;

   typedef struct packed {
      logic        valid;
      logic        linear;
      logic        shortest;
      logic [31:0] target;
      logic [31:0] feed;
   } motion_cmd_t;

   typedef struct packed {
      logic in_coarse;
      logic in_fine;
      logic move_done;
      logic dtg_delete;
   } axis_fb_t;
endpackage

//--- rtl/axis_oscillation_sequencer.sv
// Purpose: Per-axis oscillation sequencer with Avalon-MM registers.
// Assumes: Interpolator reports in-position windows and deletion events.
// Notes:   Several axes are served by instantiating one copy per axis.
`timescale 1ns/10ps
`default_nettype none
module axis_oscillation_sequencer #(
   parameter int unsigned dwell_unit_cycles = osc_pkg::dwell_unit_cyc,
   parameter int unsigned ipo_period_cycles = osc_pkg::ipo_cycle_cyc
) (
   // Clock and reset
   input  wire logic                       core_clk_in,
   input  wire logic                       rst_n_in,
   // Avalon-MM slave
   input  wire logic [osc_pkg::addr_w-1:0] avs_address_in,
   input  wire logic                       avs_read_in,
   input  wire logic                       avs_write_in,
   input  wire logic [31:0]                avs_writedata_in,
   output logic [31:0]                     avs_readdata_out,
   output logic                            avs_waitrequest_out,
   // Axis feedback
   input  wire osc_pkg::axis_fb_t          axis_fb_in,
   input  wire logic [31:0]                axis_pos_in,
   // Motion command and status
   output osc_pkg::motion_cmd_t            motion_cmd_out,
   output logic                            busy_out,
   output logic                            abort_out
);
   osc_pkg::seq_state_t state;
   osc_pkg::seq_state_t next_state;
   osc_pkg::seq_state_t stop_next;
   logic [6:0]  ctrl;
   logic [31:0] pos_one, pos_two, dwell_one, dwell_two, feed, strokes, park, offset;
   logic [31:0] live_one, live_two, live_dwell_one, live_dwell_two, feed_eff;
   logic [31:0] lim_lo, lim_hi, rem_strokes, dwell_cnt, tick_cnt;
   logic [31:0] unit_cnt;
   logic [31:0] park_tgt;
   logic        park_set, osc_on, lim_en, rotary, at_one, stop_req, del_seen;
   logic        pend_one, pend_two, pend_feed, abort, limit_hit, ack;
   logic [3:0]  work_cnt;
   logic        ipo_tick;
   logic [31:0] last_pos;

   // Bus decode
   // Writes land at the edge where waitrequest is low
   wire         wr_hit    = avs_write_in && ack;
   wire         rd_hit    = avs_read_in && !ack;
   wire         wr_set    = wr_hit && avs_address_in == osc_pkg::reg_ctrl_set;
   wire         wr_clr    = wr_hit && avs_address_in == osc_pkg::reg_ctrl_clr;
   wire         wr_p1     = wr_hit && avs_address_in == osc_pkg::reg_pos_one;
   wire         wr_p2     = wr_hit && avs_address_in == osc_pkg::reg_pos_two;
   wire         wr_d1     = wr_hit && avs_address_in == osc_pkg::reg_dwell_one;
   wire         wr_d2     = wr_hit && avs_address_in == osc_pkg::reg_dwell_two;
   wire         wr_feed   = wr_hit && avs_address_in == osc_pkg::reg_feed;
   wire         wr_str    = wr_hit && avs_address_in == osc_pkg::reg_strokes;
   wire         wr_park   = wr_hit && avs_address_in == osc_pkg::reg_park;
   wire         wr_sw     = wr_hit && avs_address_in == osc_pkg::reg_switch;
   wire         wr_off    = wr_hit && avs_address_in == osc_pkg::reg_offset;
   wire         wr_lim    = wr_hit && avs_address_in == osc_pkg::reg_limits;
   wire         wr_limh   = wr_hit && avs_address_in == osc_pkg::reg_limit_hi;
   wire         rel_val   = avs_writedata_in[osc_pkg::val_rel];
   wire [31:0]  rel_body  = {avs_writedata_in[30], avs_writedata_in[30:0]};
   // Relative value is previous point plus value plus offset
   wire [31:0]  new_p1    = rel_val ? pos_one + rel_body + offset : avs_writedata_in + offset;
   wire [31:0]  new_p2    = rel_val ? pos_two + rel_body + offset : avs_writedata_in + offset;
   wire         running   = state != osc_pkg::s_idle && state != osc_pkg::s_done;
   wire         opt4      = |(ctrl & osc_pkg::opt_park);
   wire         opt8      = |(ctrl & osc_pkg::opt_del_strokes);
   wire         opt16     = |(ctrl & osc_pkg::opt_del_target);
   wire         opt32     = |(ctrl & osc_pkg::opt_feed_defer);
   wire         opt64     = |(ctrl & osc_pkg::opt_shortest);
   wire [1:0]   tgt_sel   = ctrl[1:0];
   wire         moving    = state == osc_pkg::s_to_one || state == osc_pkg::s_to_two;
   wire [31:0]  cur_tgt   = at_one ? live_two : live_one;
   wire [31:0]  dwell_now = at_one ? live_dwell_two : live_dwell_one;
   // Reversal condition by dwell code
   wire         coarse_ok = axis_fb_in.in_coarse && dwell_now == osc_pkg::dwell_coarse;
   wire         fine_ok   = axis_fb_in.in_fine && !dwell_now[31];
   wire         rev_point = moving && axis_fb_in.move_done && (coarse_ok || fine_ok);
   wire         dwell_run = rev_point && dwell_now != osc_pkg::dwell_fine && !dwell_now[31];
   wire         dwell_end = state == osc_pkg::s_dwell && dwell_cnt == 32'h0 && unit_cnt == 32'h0;
   wire         reversal  = (rev_point && !dwell_run) || dwell_end;
   wire         stop_at   = tgt_sel == osc_pkg::tgt_one ? !at_one :
                            tgt_sel == osc_pkg::tgt_two ? at_one : 1'b1;
   wire         stop_now  = stop_req && (stop_at || tgt_sel == osc_pkg::tgt_none);
   wire         want_park = opt4 || (del_seen && opt8);
   wire         pos_in_lim = !lim_en || ($signed(cur_tgt) >= $signed(lim_lo) && $signed(cur_tgt) <= $signed(lim_hi));

   assign ack                 = !avs_waitrequest_out;
   assign ipo_tick            = tick_cnt == 32'h0;

   // Bus write state and control word
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_waitrequest_out <= 1'b1;
         ctrl <= 7'h00;
         pos_one <= 32'h0;
         pos_two <= 32'h0;
         dwell_one <= 32'h0;
         dwell_two <= 32'h0;
         feed <= 32'h0;
         strokes <= 32'h0;
         park <= 32'h0;
         park_set <= 1'b0;
         offset <= 32'h0;
         lim_lo <= 32'h0;
         lim_hi <= 32'h0;
         lim_en <= 1'b0;
         rotary <= 1'b0;
      end else begin
         avs_waitrequest_out <= !((avs_read_in || avs_write_in) && avs_waitrequest_out);
         // Writes land while motion continues
         if (wr_set || wr_park) begin
            ctrl <= ctrl | (wr_park ? osc_pkg::opt_park : avs_writedata_in[6:0]);
         end else if (wr_clr) begin
            ctrl <= ctrl & ~avs_writedata_in[6:0];
         end
         if (wr_p1) pos_one <= new_p1;
         if (wr_p2) pos_two <= new_p2;
         if (wr_d1) dwell_one <= avs_writedata_in;
         if (wr_d2) dwell_two <= avs_writedata_in;
         if (wr_feed) feed <= avs_writedata_in;
         if (wr_str) strokes <= avs_writedata_in;
         if (wr_park) park <= avs_writedata_in + offset;
         if (wr_park) park_set <= 1'b1;
         if (wr_off) offset <= avs_writedata_in;
         if (wr_lim) lim_lo <= avs_writedata_in;
         if (wr_limh) lim_hi <= avs_writedata_in;
         if (wr_set) lim_en <= lim_en | avs_writedata_in[8 + osc_pkg::lim_enable];
         if (wr_set) rotary <= rotary | avs_writedata_in[8 + osc_pkg::lim_rotary];
         if (wr_clr) lim_en <= lim_en & ~avs_writedata_in[8 + osc_pkg::lim_enable];
         if (wr_clr) rotary <= rotary & ~avs_writedata_in[8 + osc_pkg::lim_rotary];
      end
   end

   // Read mux
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_readdata_out <= 32'h0;
      end else if (rd_hit) begin
         unique case (avs_address_in)
            osc_pkg::reg_ctrl_set:  avs_readdata_out <= {22'h0, lim_en, rotary, 1'b0, ctrl};
            osc_pkg::reg_pos_one:   avs_readdata_out <= pos_one;
            osc_pkg::reg_pos_two:   avs_readdata_out <= pos_two;
            osc_pkg::reg_dwell_one: avs_readdata_out <= dwell_one;
            osc_pkg::reg_dwell_two: avs_readdata_out <= dwell_two;
            osc_pkg::reg_feed:      avs_readdata_out <= feed_eff;
            osc_pkg::reg_strokes:   avs_readdata_out <= rem_strokes;
            osc_pkg::reg_park:      avs_readdata_out <= park;
            osc_pkg::reg_switch:    avs_readdata_out <= {31'h0, osc_on};
            osc_pkg::reg_offset:    avs_readdata_out <= offset;
            osc_pkg::reg_status:    avs_readdata_out <= {27'h0, limit_hit, at_one, abort, osc_on, busy_out};
            osc_pkg::reg_live_one:  avs_readdata_out <= live_one;
            osc_pkg::reg_live_two:  avs_readdata_out <= live_two;
            osc_pkg::reg_limits:    avs_readdata_out <= lim_lo;
            osc_pkg::reg_limit_hi:  avs_readdata_out <= lim_hi;
            default:                avs_readdata_out <= 32'h0;
         endcase
      end
   end

   // Sequencer next state
   always_comb begin
      next_state = state;
      stop_next = osc_pkg::s_done;
      if (rem_strokes != 32'h0) stop_next = osc_pkg::s_strokes;
      else if (want_park && park_set) stop_next = osc_pkg::s_park;
      unique case (state)
         osc_pkg::s_idle:
            if (osc_on) next_state = osc_pkg::s_to_one;
         osc_pkg::s_to_one, osc_pkg::s_to_two:
            if (rev_point && dwell_run) next_state = osc_pkg::s_dwell;
            else if (reversal && stop_now) next_state = stop_next;
            else if (reversal) next_state = at_one ? osc_pkg::s_to_one : osc_pkg::s_to_two;
         osc_pkg::s_dwell:
            if (dwell_end && stop_now) next_state = stop_next;
            else if (dwell_end) next_state = at_one ? osc_pkg::s_to_one : osc_pkg::s_to_two;
         osc_pkg::s_stop_pt:
            next_state = osc_pkg::s_to_one;
         osc_pkg::s_strokes:
            if (rem_strokes == 32'h0 && ipo_tick)
               next_state = (want_park && park_set) ? osc_pkg::s_park : osc_pkg::s_done;
         osc_pkg::s_park:
            if (axis_fb_in.move_done && axis_fb_in.in_fine) next_state = osc_pkg::s_done;
         osc_pkg::s_done:
            if (!osc_on) next_state = osc_pkg::s_idle;
         default: next_state = osc_pkg::s_idle;
      endcase
      if (abort) next_state = osc_pkg::s_done;
   end

   // Sequencer registers
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= osc_pkg::s_idle;
         osc_on <= 1'b0;
         stop_req <= 1'b0;
         del_seen <= 1'b0;
         at_one <= 1'b0;
         rem_strokes <= 32'h0;
         dwell_cnt <= 32'h0;
         unit_cnt <= 32'h0;
      end else begin
         state <= next_state;
         if (wr_sw) osc_on <= avs_writedata_in[osc_pkg::sw_on];
         else if (state == osc_pkg::s_done && stop_req) osc_on <= 1'b0;
         if (wr_sw && !avs_writedata_in[osc_pkg::sw_on] && running) stop_req <= 1'b1;
         else if (axis_fb_in.dtg_delete && running && (opt8 || opt16)) stop_req <= 1'b1;
         else if (state == osc_pkg::s_idle) stop_req <= 1'b0;
         if (axis_fb_in.dtg_delete && running) del_seen <= 1'b1;
         else if (state == osc_pkg::s_idle) del_seen <= 1'b0;
         if (state == osc_pkg::s_idle) at_one <= 1'b0;
         else if (reversal && !stop_now) at_one <= !at_one;
         if (state == osc_pkg::s_idle) rem_strokes <= strokes;
         else if (state == osc_pkg::s_strokes && ipo_tick && rem_strokes != 32'h0 && axis_fb_in.move_done)
            rem_strokes <= rem_strokes - 32'h1;
         if (dwell_run) begin
            dwell_cnt <= dwell_now - 32'h1;
            unit_cnt <= dwell_unit_cycles - 32'h1;
         end else if (state == osc_pkg::s_dwell) begin
            if (unit_cnt != 32'h0) unit_cnt <= unit_cnt - 32'h1;
            else if (dwell_cnt != 32'h0) begin
               dwell_cnt <= dwell_cnt - 32'h1;
               unit_cnt <= dwell_unit_cycles - 32'h1;
            end
         end
      end
   end

   // Point, dwell and feedrate take-up
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         live_one <= 32'h0;
         live_two <= 32'h0;
         live_dwell_one <= 32'h0;
         live_dwell_two <= 32'h0;
         feed_eff <= 32'h0;
         pend_one <= 1'b0;
         pend_two <= 1'b0;
         pend_feed <= 1'b0;
      end else begin
         pend_one <= (pend_one || wr_p1 || wr_d1) && !(running && at_one && reversal) && running;
         pend_two <= (pend_two || wr_p2 || wr_d2) && !(running && !at_one && reversal) && running;
         // Updates wait for next approach of that point
         if (!running || (reversal && !at_one) || (pend_one && !at_one && rev_point)) begin
            live_one <= pos_one;
            live_dwell_one <= dwell_one;
         end
         if (!running || (reversal && at_one)) begin
            live_two <= pos_two;
            live_dwell_two <= dwell_two;
         end
         if (wr_feed && opt32 && running) pend_feed <= 1'b1;
         else if (reversal) pend_feed <= 1'b0;
         if ((!opt32 || !running) && ipo_tick) feed_eff <= feed;
         else if (opt32 && reversal) feed_eff <= feed;
      end
   end

   // Interpolation cycle and work budget
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tick_cnt <= 32'h0;
         work_cnt <= 4'h0;
         abort <= 1'b0;
         last_pos <= 32'h0;
      end else begin
         tick_cnt <= ipo_tick ? ipo_period_cycles - 32'h1 : tick_cnt - 32'h1;
         last_pos <= axis_pos_in;
         if (ipo_tick) work_cnt <= 4'h0;
         else if (wr_hit && work_cnt != 4'hf) work_cnt <= work_cnt + 4'h1;
         if (work_cnt >= 4'(osc_pkg::work_budget_cyc) && running) abort <= 1'b1;
         else if (state == osc_pkg::s_idle) abort <= 1'b0;
      end
   end

   // Motion command toward the interpolator
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         motion_cmd_out <= '0;
         busy_out <= 1'b0;
         abort_out <= 1'b0;
         limit_hit <= 1'b0;
      end else begin
         motion_cmd_out.valid <= (moving && pos_in_lim) || state == osc_pkg::s_park || state == osc_pkg::s_strokes;
         motion_cmd_out.linear <= 1'b1;
         motion_cmd_out.shortest <= opt64 && rotary;
         motion_cmd_out.target <= state == osc_pkg::s_park ? park :
                                  state == osc_pkg::s_strokes ? (rem_strokes[0] ? live_two : live_one) : cur_tgt;
         motion_cmd_out.feed <= feed_eff;
         limit_hit <= moving && !pos_in_lim;
         busy_out <= running || osc_on;
         abort_out <= abort;
      end
   end
endmodule
`default_nettype wire

//--- dv/osc_axis_model.sv
// Purpose: Behavioural axis interpolator and drive.
// Assumes: Each leg settles a fixed count of cycles.
// Notes:   Coarse window shows one cycle before fine.
`timescale 1ns/10ps
`default_nettype none
module osc_axis_model #(
   parameter int settle = 3
) (
   // Clock and reset
   input  wire logic                 core_clk_in,
   input  wire logic                 rst_n_in,
   // Sequencer side
   input  wire osc_pkg::motion_cmd_t cmd_in,
   input  wire logic                 delete_in,
   output osc_pkg::axis_fb_t         fb_out,
   output logic [31:0]               pos_out
);
   logic [7:0] cnt;
   wire        moving = cmd_in.valid && cmd_in.target != pos_out;
   always_ff @(posedge core_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= 8'h00;
         fb_out <= '0;
         pos_out <= 32'h00000000;
      end else begin
         fb_out.dtg_delete <= delete_in;
         fb_out.move_done <= 1'b0;
         cnt <= moving ? cnt + 8'h01 : 8'h00;
         if (moving) begin
            fb_out.in_coarse <= 1'b0;
            fb_out.in_fine <= 1'b0;
         end
         if (moving && cnt == 8'(settle)) begin
            pos_out <= cmd_in.target;
            fb_out.in_coarse <= 1'b1;
         end else if (!moving && fb_out.in_coarse && !fb_out.in_fine) begin
            fb_out.in_fine <= 1'b1;
            fb_out.move_done <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

//--- dv/axis_oscillation_sequencer_properties.sv
// Purpose: Port checks for the oscillation sequencer.
// Assumes: Every access takes two cycles.
// Notes:   Bound into each sequencer copy.
`timescale 1ns/10ps
`default_nettype none
module osc_seq_properties (
   input wire logic                       core_clk_in,
   input wire logic                       rst_n_in,
   input wire logic [osc_pkg::addr_w-1:0] avs_address_in,
   input wire logic                       avs_read_in,
   input wire logic                       avs_write_in,
   input wire logic [31:0]                avs_writedata_in,
   input wire logic [31:0]                avs_readdata_out,
   input wire logic                       avs_waitrequest_out,
   input wire osc_pkg::axis_fb_t          axis_fb_in,
   input wire osc_pkg::motion_cmd_t       motion_cmd_out,
   input wire logic                       busy_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire req = avs_read_in || avs_write_in;
   wire sw_on = avs_write_in && !avs_waitrequest_out && avs_address_in == osc_pkg::reg_switch;
   AST_LINEAR: assert property (motion_cmd_out.valid |-> motion_cmd_out.linear)
      else $error("Motion not linear");
   AST_WAIT_ONE: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("Access not answered in one cycle");
   AST_WAIT_PULSE: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("Waitrequest low too long");
   AST_WAIT_IDLE: assert property (!req |=> avs_waitrequest_out)
      else $error("Waitrequest low without request");
   AST_VALID_BUSY: assert property (motion_cmd_out.valid |-> busy_out)
      else $error("Motion while not busy");
   AST_BUSY_END: assert property ($fell(busy_out) |-> !motion_cmd_out.valid)
      else $error("Busy ended during motion");
   AST_READ_HOLD: assert property (!avs_read_in |=> $stable(avs_readdata_out))
      else $error("Read data changed without read");
   AST_SWITCH_ON: assert property (sw_on && avs_writedata_in[0] |-> ##[1:4] busy_out)
      else $error("Switch on did not start");
   COV_DONE: cover property (motion_cmd_out.valid && axis_fb_in.move_done);
   COV_DEL: cover property (axis_fb_in.dtg_delete && busy_out);
   COV_END: cover property ($fell(busy_out));
endmodule
bind axis_oscillation_sequencer osc_seq_properties i_props (.core_clk_in, .rst_n_in, .avs_address_in,
   .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
   .axis_fb_in, .motion_cmd_out, .busy_out);
`default_nettype wire

//--- dv/tb_axis_oscillation_sequencer.sv
// Purpose: Self-checking bench for the oscillation sequencer.
// Assumes: Short dwell unit and interpolation period.
// Notes:   Checks at the falling edge; bus answers at the rising edge.
`timescale 1ns/10ps
`default_nettype none
module tb_axis_oscillation_sequencer;
   logic                 clk;
   logic                 rst_n;
   logic [3:0]           av_addr;
   logic                 av_rd;
   logic                 av_wr;
   logic [31:0]          av_wdata;
   logic [31:0]          av_rdata;
   logic                 av_wait;
   logic                 del_req;
   logic                 busy;
   logic                 abort;
   logic [31:0]          pos;
   logic [31:0]          rd;
   osc_pkg::axis_fb_t    fb;
   osc_pkg::motion_cmd_t cmd;
   int                   error_cnt = 0;
   int                   compares = 0;
   axis_oscillation_sequencer #(.dwell_unit_cycles(4), .ipo_period_cycles(16)) i_dut (
      .core_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(av_addr), .avs_read_in(av_rd),
      .avs_write_in(av_wr), .avs_writedata_in(av_wdata), .avs_readdata_out(av_rdata),
      .avs_waitrequest_out(av_wait), .axis_fb_in(fb), .axis_pos_in(pos), .motion_cmd_out(cmd),
      .busy_out(busy), .abort_out(abort));
   osc_axis_model i_axis (.core_clk_in(clk), .rst_n_in(rst_n), .cmd_in(cmd), .delete_in(del_req),
      .fb_out(fb), .pos_out(pos));
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      av_addr <= a;
      av_wdata <= d;
      av_wr <= wr;
      av_rd <= !wr;
      @(posedge clk);
      while (av_wait !== 1'b0) @(posedge clk);
      rd = av_rdata;
      av_wr <= 1'b0;
      av_rd <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wait_pos(input logic [31:0] tgt);
      int n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (!(cmd.target === tgt && pos === tgt) && n < 3000);
      chk(pos, tgt);
      chk(32'(cmd.linear), 32'h00000001);
      @(posedge clk);
   endtask
   task automatic wait_idle();
      int n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (busy !== 1'b0 && n < 3000);
      chk(32'(busy), 32'h00000000);
      @(posedge clk);
   endtask
   task automatic t_ctrl();
      bus(1'b1, osc_pkg::reg_ctrl_set, 32'h00000015);
      bus(1'b1, osc_pkg::reg_ctrl_clr, 32'h00000068);
      bus(1'b0, osc_pkg::reg_ctrl_set, 32'h00000000);
      chk(rd & 32'h0000007f, 32'h00000015);
      bus(1'b1, osc_pkg::reg_ctrl_clr, 32'h0000007f);
      bus(1'b1, osc_pkg::reg_park, 32'h00000096);
      bus(1'b0, osc_pkg::reg_ctrl_set, 32'h00000000);
      chk(rd & 32'h0000007f, 32'h00000004);
   endtask
   task automatic t_osc();
      bus(1'b1, osc_pkg::reg_pos_one, 32'h00000032);
      bus(1'b1, osc_pkg::reg_pos_two, 32'h00000032);
      bus(1'b1, osc_pkg::reg_pos_two, 32'h80000032);
      bus(1'b1, osc_pkg::reg_dwell_two, 32'h00000001);
      bus(1'b1, osc_pkg::reg_feed, 32'h00000010);
      bus(1'b1, osc_pkg::reg_ctrl_set, 32'h00000142);
      bus(1'b1, osc_pkg::reg_switch, 32'h00000001);
      @(negedge clk);
      chk(32'(busy), 32'h00000001);
      wait_pos(32'h00000064);
      repeat (4) @(negedge clk);
      chk(32'(cmd.valid), 32'h00000000);
      wait_pos(32'h00000032);
      @(negedge clk);
      chk(cmd.feed, 32'h00000010);
      chk(32'(cmd.shortest), 32'h00000001);
      @(posedge clk);
      bus(1'b0, osc_pkg::reg_live_one, 32'h00000000);
      chk(rd, 32'h00000032);
      bus(1'b0, osc_pkg::reg_live_two, 32'h00000000);
      chk(rd, 32'h00000064);
      bus(1'b1, osc_pkg::reg_switch, 32'h00000000);
      wait_pos(32'h00000064);
      wait_pos(32'h00000096);
      wait_idle();
      chk(32'(abort), 32'h00000000);
   endtask
   task automatic t_del();
      wait_idle();
      bus(1'b1, osc_pkg::reg_ctrl_clr, 32'h0000007f);
      bus(1'b1, osc_pkg::reg_ctrl_set, 32'h00000011);
      bus(1'b1, osc_pkg::reg_switch, 32'h00000001);
      wait_pos(32'h00000064);
      del_req <= 1'b1;
      @(posedge clk);
      del_req <= 1'b0;
      wait_pos(32'h00000032);
      wait_idle();
      chk(pos, 32'h00000032);
   endtask
   task automatic final_report();
      if (error_cnt == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      rst_n = 1'b0;
      av_addr = 4'h0;
      av_rd = 1'b0;
      av_wr = 1'b0;
      av_wdata = 32'h00000000;
      del_req = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_ctrl();
      t_osc();
      t_del();
      final_report();
   end
   initial begin
      repeat (50000) @(posedge clk);
      error_cnt++;
      final_report();
   end
endmodule
`default_nettype wire
